/* File: logic/motor_protect_regs.vh */
/*
  Register offsets, field positions and reset values of the motor drive
  protection block. Assumes an 8-bit register port with a 3-bit address.
*/
`ifndef MOTOR_PROTECT_REGS_VH
`define MOTOR_PROTECT_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_TRIGGER_CONTROL 3'h0
`define OFS_MODE_CONTROL    3'h1
`define OFS_OVERRIDE_LEVEL  3'h2
`define OFS_MOTOR_CONFIG    3'h3
`define OFS_STATUS          3'h4

// ----------------------------------------------------------------------
// protection_trigger_control fields
// ----------------------------------------------------------------------
`define BIT_OVERRIDE_HW_EN   0
`define BIT_OVERRIDE_SW_TRIG 1
`define BIT_CLIMIT_HW_EN     2
`define BIT_OCPULSE_HW_EN    3
`define BIT_CAPCMP_EN        4
`define BIT_CAPOVF_EN        5
`define BIT_SW_PROT_EN       6
`define BIT_SW_PROT_DATA     7

// ----------------------------------------------------------------------
// protection_mode_control fields
// ----------------------------------------------------------------------
`define BIT_CAPOVF_MODE      0
`define BIT_CAPCMP_MODE      1
`define BIT_OCPULSE_MODE     2
`define BIT_CLIMIT_RESTART   3
`define BIT_SW_PROT_MODE     4
`define BIT_CYCLE_EN         5
`define BIT_OVERRIDE_SRC     6

// ----------------------------------------------------------------------
// reset values, fixed patterns and filter length
// ----------------------------------------------------------------------
`define RST_TRIGGER_CONTROL  8'h00
`define RST_MODE_CONTROL     7'h00
`define RST_OVERRIDE_LEVEL   4'h0
`define RST_MOTOR_CONFIG     1'h0
`define BRAKE_PATTERN        4'hA
`define FREE_RUN_PATTERN     4'h0
`define OC_FILTER_CYCLES     2

`endif

/* File: logic/motor_drive_protection.v */
/*
  Motor drive protection: shutdown (brake or free-run) on stall, over-current,
  current-limit or software triggers, plus a fast over-current override that
  forces preset gate levels. Assumes the capture timer, current-limit logic
  and PWM timer run on clk; the two comparator outputs are asynchronous.
*/
`timescale 1ns/10ps
`include "motor_protect_regs.vh"

module motor_drive_protection (
  input  wire       clk,
  input  wire       nrst,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire [3:0] drive_in,
  input  wire       comparator_zero_out,
  input  wire       comparator_one_out,
  input  wire       current_limit_event,
  input  wire       adc_opa_selected,
  input  wire       capture_compare_stall_event,
  input  wire       capture_overflow_stall_event,
  input  wire       pwm_period_start,
  output reg  [3:0] gate_out,
  output reg        shutdown_active,
  output reg        fast_overcurrent_override,
  output reg        pwm_cutoff
);

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  reg  [7:0] protection_trigger_control_reg;
  reg  [6:0] protection_mode_control_reg;
  reg  [3:0] override_level_reg;
  reg        motor_config_reg;

  wire override_hw_enable           = protection_trigger_control_reg[`BIT_OVERRIDE_HW_EN];
  wire override_sw_trigger          = protection_trigger_control_reg[`BIT_OVERRIDE_SW_TRIG];
  wire current_limit_hw_enable      = protection_trigger_control_reg[`BIT_CLIMIT_HW_EN];
  wire overcurrent_pulse_hw_enable  = protection_trigger_control_reg[`BIT_OCPULSE_HW_EN];
  wire capture_compare_stall_enable = protection_trigger_control_reg[`BIT_CAPCMP_EN];
  wire capture_overflow_stall_enable = protection_trigger_control_reg[`BIT_CAPOVF_EN];
  wire sw_protection_enable         = protection_trigger_control_reg[`BIT_SW_PROT_EN];
  wire sw_protection_data           = protection_trigger_control_reg[`BIT_SW_PROT_DATA];
  // mode bits: pulse zero fault one pause; stall and software sources act only at one
  wire capture_overflow_mode_select = protection_mode_control_reg[`BIT_CAPOVF_MODE];
  wire capture_compare_mode_select  = protection_mode_control_reg[`BIT_CAPCMP_MODE];
  wire overcurrent_pulse_mode_select = protection_mode_control_reg[`BIT_OCPULSE_MODE];
  wire current_limit_restart_select = protection_mode_control_reg[`BIT_CLIMIT_RESTART];
  wire sw_protection_mode_select    = protection_mode_control_reg[`BIT_SW_PROT_MODE];
  wire cycle_by_cycle_enable        = protection_mode_control_reg[`BIT_CYCLE_EN];
  wire override_source_select       = protection_mode_control_reg[`BIT_OVERRIDE_SRC];
  wire shutdown_state_select        = motor_config_reg;

  // ----------------------------------------------------------------------
  // internal state
  // ----------------------------------------------------------------------
  reg  [1:0] cmp0_sync_reg;
  reg  [1:0] comparator_one_sync_reg;
  reg  [`OC_FILTER_CYCLES-1:0] oc_filter_reg;
  reg        oc_level_d_reg;
  reg        comparator_one_d_reg;
  reg        oc_pause_reg;
  reg        climit_hold_reg;
  reg        cycle_off_reg;
  reg        capcmp_latch_reg;
  reg        capovf_latch_reg;
  reg        override_latch_reg;
  reg        override_hw_en_d_reg;
  reg        sw_en_d_reg;
  reg        sw_data_d_reg;
  reg        sw_en_fell_reg;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // one decode chain; unmapped and status writes are dropped
  always @(posedge clk) begin
    if (!nrst) begin
      protection_trigger_control_reg <= `RST_TRIGGER_CONTROL;
      protection_mode_control_reg    <= `RST_MODE_CONTROL;
      override_level_reg             <= `RST_OVERRIDE_LEVEL;
      motor_config_reg               <= `RST_MOTOR_CONFIG;
    end else if (wr_stb) begin
      if (addr == `OFS_TRIGGER_CONTROL) begin
        protection_trigger_control_reg <= wdata;
      end else if (addr == `OFS_MODE_CONTROL) begin
        protection_mode_control_reg <= wdata[6:0];
      end else if (addr == `OFS_OVERRIDE_LEVEL) begin
        override_level_reg <= wdata[3:0];
      end else if (addr == `OFS_MOTOR_CONFIG) begin
        motor_config_reg <= wdata[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // comparator input conditioning
  // ----------------------------------------------------------------------
  // two-flop synchronisers; first stage read only by the second
  always @(posedge clk) begin
    if (!nrst) begin
      cmp0_sync_reg <= 2'b00;
      comparator_one_sync_reg <= 2'b00;
      comparator_one_d_reg    <= 1'b0;
    end else begin
      cmp0_sync_reg <= {cmp0_sync_reg[0], comparator_zero_out};
      comparator_one_sync_reg <= {comparator_one_sync_reg[0], comparator_one_out};
      comparator_one_d_reg    <= comparator_one_sync_reg[1];
    end
  end

  // filtered level, its first cycle as the pulse, comparator one edge
  wire oc_level = &oc_filter_reg;
  wire comparator_overcurrent_pulse = oc_level & ~oc_level_d_reg;
  wire comparator_one_rise = comparator_one_sync_reg[1] & ~comparator_one_d_reg;

  // two-clock filter
  // glitches shorter than the filter never reach the protection logic
  always @(posedge clk) begin
    if (!nrst) begin
      oc_filter_reg  <= {`OC_FILTER_CYCLES{1'b0}};
      oc_level_d_reg <= 1'b0;
    end else begin
      oc_filter_reg  <= {oc_filter_reg[`OC_FILTER_CYCLES-2:0], cmp0_sync_reg[1]};
      oc_level_d_reg <= oc_level;
    end
  end

  // ----------------------------------------------------------------------
  // software release detection
  // ----------------------------------------------------------------------
  // enable high-low-high
  // the fall is remembered so a later rise releases the latches
  always @(posedge clk) begin
    if (!nrst) begin
      sw_en_d_reg    <= 1'b0;
      sw_data_d_reg  <= 1'b0;
      sw_en_fell_reg <= 1'b0;
    end else begin
      sw_en_d_reg   <= sw_protection_enable;
      sw_data_d_reg <= sw_protection_data;
      if (sw_en_d_reg && !sw_protection_enable) begin
        sw_en_fell_reg <= 1'b1;
      end else if (sw_protection_enable) begin
        sw_en_fell_reg <= 1'b0;
      end
    end
  end

  // data bit releases
  // a release is an enable re-arm or the data bit falling while enabled
  wire sw_en_rearm = sw_en_fell_reg & sw_protection_enable & ~sw_en_d_reg;
  wire sw_data_fall = sw_protection_enable & sw_data_d_reg & ~sw_protection_data;
  wire sw_release = sw_en_rearm | sw_data_fall;
  wire sw_shutdown = sw_protection_enable & sw_protection_mode_select & sw_protection_data;

  // ----------------------------------------------------------------------
  // trigger sources
  // ----------------------------------------------------------------------
  // pulse enable gate
  wire oc_enabled = overcurrent_pulse_hw_enable;
  // fault mode follows the filtered level
  wire oc_fault = oc_enabled & ~overcurrent_pulse_mode_select & oc_level;
  wire climit_active = current_limit_hw_enable & adc_opa_selected & current_limit_event;

  // pause latches; set wins over a same-cycle release
  // capture compare stall, capture overflow stall
  always @(posedge clk) begin
    if (!nrst) begin
      oc_pause_reg     <= 1'b0;
      capcmp_latch_reg <= 1'b0;
      capovf_latch_reg <= 1'b0;
    end else begin
      if (oc_enabled && overcurrent_pulse_mode_select && comparator_overcurrent_pulse) begin
        oc_pause_reg <= 1'b1;
      end else if (sw_release) begin
        oc_pause_reg <= 1'b0;
      end
      if (capture_compare_stall_enable && capture_compare_mode_select &&
          capture_compare_stall_event) begin
        capcmp_latch_reg <= 1'b1;
      end else if (sw_release) begin
        capcmp_latch_reg <= 1'b0;
      end
      if (capture_overflow_stall_enable && capture_overflow_mode_select &&
          capture_overflow_stall_event) begin
        capovf_latch_reg <= 1'b1;
      end else if (sw_release) begin
        capovf_latch_reg <= 1'b0;
      end
    end
  end

  // restart select
  // with restart at period the hold outlives the event until the boundary
  always @(posedge clk) begin
    if (!nrst) begin
      climit_hold_reg <= 1'b0;
    end else if (climit_active) begin
      climit_hold_reg <= 1'b1;
    end else if (!current_limit_restart_select || pwm_period_start) begin
      climit_hold_reg <= 1'b0;
    end
  end

  // cycle-by-cycle cut
  // retried only at a period boundary or when disabled; a persisting condition re-cuts at once
  always @(posedge clk) begin
    if (!nrst) begin
      cycle_off_reg <= 1'b0;
    end else if (cycle_by_cycle_enable && oc_level) begin
      cycle_off_reg <= 1'b1;
    end else if (pwm_period_start || !cycle_by_cycle_enable) begin
      cycle_off_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // fast over-current override
  // ----------------------------------------------------------------------
  // override source select
  wire ovr_hw_source = override_source_select ? comparator_one_rise
                                              : (comparator_overcurrent_pulse & oc_enabled);

  // only software clears it
  // a trigger in the clearing cycle wins, so no event is lost
  always @(posedge clk) begin
    if (!nrst) begin
      override_latch_reg   <= 1'b0;
      override_hw_en_d_reg <= 1'b0;
    end else begin
      override_hw_en_d_reg <= override_hw_enable;
      if (override_hw_enable && ovr_hw_source) begin
        override_latch_reg <= 1'b1;
      end else if (override_hw_enable && !override_hw_en_d_reg) begin
        override_latch_reg <= 1'b0;
      end
    end
  end

  wire override_now = override_latch_reg | override_sw_trigger;

  // ----------------------------------------------------------------------
  // shutdown and gate drive
  // ----------------------------------------------------------------------
  // any source but the cycle-by-cycle cut and the override asserts shutdown
  wire shutdown_now = oc_fault | oc_pause_reg | climit_active | climit_hold_reg |
                      capcmp_latch_reg | capovf_latch_reg | sw_shutdown;

  wire [3:0] safe_pattern = shutdown_state_select ? `FREE_RUN_PATTERN : `BRAKE_PATTERN;

  // reset drives all gates low
  // outputs registered: one clock of latency traded for glitch-free gates
  always @(posedge clk) begin
    if (!nrst) begin
      gate_out                  <= 4'h0;
      shutdown_active           <= 1'b0;
      fast_overcurrent_override <= 1'b0;
      pwm_cutoff                <= 1'b0;
    end else begin
      shutdown_active           <= shutdown_now;
      fast_overcurrent_override <= override_now;
      pwm_cutoff                <= cycle_off_reg;
      if (override_now) begin
        gate_out <= override_level_reg;
      end else if (shutdown_now) begin
        gate_out <= safe_pattern;
      end else if (cycle_off_reg) begin
        gate_out <= `FREE_RUN_PATTERN;
      end else begin
        gate_out <= drive_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  // status shows live protection state; unmapped reads return zero
  wire [7:0] status_word = {oc_fault, cycle_off_reg, climit_hold_reg, oc_pause_reg,
                            capovf_latch_reg, capcmp_latch_reg, override_now, shutdown_now};

  always @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (addr == `OFS_TRIGGER_CONTROL) begin
        rdata <= protection_trigger_control_reg;
      end else if (addr == `OFS_MODE_CONTROL) begin
        rdata <= {1'b0, protection_mode_control_reg};
      end else if (addr == `OFS_OVERRIDE_LEVEL) begin
        rdata <= {4'h0, override_level_reg};
      end else if (addr == `OFS_MOTOR_CONFIG) begin
        rdata <= {7'h00, motor_config_reg};
      end else if (addr == `OFS_STATUS) begin
        rdata <= status_word;
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

/* File: tb/motor_drive_protection_properties.sv */
/*
  Port-level assertions for the motor drive protection block.
  Assumes it is bound into motor_drive_protection and sees only its ports.
*/
`timescale 1ns/10ps
`include "motor_protect_regs.vh"
module motor_drive_protection_properties (
  input logic       clk,
  input logic       nrst,
  input logic [2:0] addr,
  input logic [7:0] wdata,
  input logic       wr_stb,
  input logic [3:0] drive_in,
  input logic       comparator_zero_out,
  input logic       pwm_period_start,
  input logic [3:0] gate_out,
  input logic       shutdown_active,
  input logic       fast_overcurrent_override,
  input logic       pwm_cutoff
);
  // ----------------------------------------
  // shadow registers
  // ----------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [3:0] lvl_reg;
  logic       cfg_reg;
  logic [2:0] ctl_wr_reg;
  logic       wr_ctl;
  logic       oc_arm;
  assign wr_ctl = wr_stb && addr == `OFS_TRIGGER_CONTROL;
  // pulse path armed: hw enable, pulse enable, source is the pulse
  assign oc_arm = ctrl_reg[0] && ctrl_reg[3] && !mode_reg[6];
  // shadows follow bus writes so expectations never lean on design state
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= 8'h00;
      mode_reg <= 8'h00;
      lvl_reg <= 4'h0;
      cfg_reg <= 1'b0;
      ctl_wr_reg <= 3'h0;
    end else begin
      ctl_wr_reg <= {ctl_wr_reg[1:0], wr_ctl};
      if (wr_ctl) ctrl_reg <= wdata;
      if (wr_stb && addr == `OFS_MODE_CONTROL) mode_reg <= wdata;
      if (wr_stb && addr == `OFS_OVERRIDE_LEVEL) lvl_reg <= wdata[3:0];
      if (wr_stb && addr == `OFS_MOTOR_CONFIG) cfg_reg <= wdata[0];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_quiet: assert property (
    $rose(nrst) |-> gate_out == 4'h0 && !shutdown_active && !fast_overcurrent_override)
    else $error("outputs not quiet after reset");
  a_override_levels: assert property (
    fast_overcurrent_override |-> gate_out == $past(lvl_reg))
    else $error("override levels not driven");
  a_shutdown_pattern: assert property (
    shutdown_active && !fast_overcurrent_override
    |-> gate_out == ($past(cfg_reg) ? `FREE_RUN_PATTERN : `BRAKE_PATTERN))
    else $error("wrong shutdown pattern");
  a_drive_passes: assert property (
    $past(nrst) && !$past(ctrl_reg[2]) && !shutdown_active && !fast_overcurrent_override
    && !pwm_cutoff |-> gate_out == $past(drive_in))
    else $error("drive not passed through");
  a_sw_override: assert property (
    ctrl_reg[`BIT_OVERRIDE_SW_TRIG] |-> ##[1:2] fast_overcurrent_override)
    else $error("software override not set");
  a_override_release: assert property (
    $fell(fast_overcurrent_override) && $past(nrst) |-> ctl_wr_reg != 3'h0)
    else $error("override dropped without a write");
  a_oc_latch: assert property (
    $rose(comparator_zero_out) && oc_arm ##1 (oc_arm && comparator_zero_out)[*7]
    |-> ##[0:2] fast_overcurrent_override)
    else $error("over-current did not latch override");
  a_oc_fault: assert property (
    (ctrl_reg[3] && !mode_reg[2] && comparator_zero_out)[*8] |-> ##[0:2] shutdown_active)
    else $error("over-current did not shut down");
  a_cut_sets: assert property (
    (mode_reg[5] && comparator_zero_out)[*8] |-> ##[0:2] pwm_cutoff)
    else $error("cycle cut not set");
  a_cut_period: assert property (
    $fell(pwm_cutoff) && $past(nrst)
    |-> $past(pwm_period_start) || $past(pwm_period_start, 2) || !mode_reg[5])
    else $error("cycle cut left outside a period start");
  c_override: cover property (fast_overcurrent_override);
  c_shutdown: cover property (shutdown_active && !fast_overcurrent_override);
  c_cut: cover property ($fell(pwm_cutoff));
endmodule
bind motor_drive_protection motor_drive_protection_properties i_props (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .drive_in(drive_in), .comparator_zero_out(comparator_zero_out),
  .pwm_period_start(pwm_period_start), .gate_out(gate_out),
  .shutdown_active(shutdown_active), .pwm_cutoff(pwm_cutoff),
  .fast_overcurrent_override(fast_overcurrent_override)
);

/* File: tb/gate_bridge_model.sv */
/*
  Model of the gate driver and transistor bridge with its current sense.
  Assumes gate_out bit order high A, low A, high B, low B.
*/
`timescale 1ns/10ps
module gate_bridge_model (
  input  logic       clk,
  input  logic [3:0] gate_out,
  input  logic       fault_req,
  input  logic       slow,
  output logic       sense_oc,
  output logic       shoot_through
);
  // ----------------------------------------
  // current build-up and leg short
  // ----------------------------------------
  logic [3:0] dly_reg = 4'h0;
  // slow builds up over four cycles, as a choke limits the rise
  always @(posedge clk) dly_reg <= {dly_reg[2:0], fault_req};
  assign sense_oc = slow ? dly_reg[3] : dly_reg[0];
  // both switches of one leg on is a dead short
  assign shoot_through = (gate_out[0] & gate_out[1]) | (gate_out[2] & gate_out[3]);
endmodule

/* File: tb/tb_motor_drive_protection.sv */
/*
  Self-checking bench for the motor drive protection block.
  Assumes the register header, the bridge model and the bound checker.
*/
`timescale 1ns/10ps
`include "motor_protect_regs.vh"
module tb_motor_drive_protection;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic [7:0] rdata;
  logic [3:0] drive_in = 4'h6;
  logic       comparator_zero_out;
  logic       comparator_one_out = 1'b0;
  logic       current_limit_event = 1'b0;
  logic       adc_opa_selected = 1'b0;
  logic [1:0] stall_ev = 2'b00;
  logic       pwm_period_start = 1'b0;
  logic [3:0] gate_out;
  logic       shutdown_active;
  logic       fast_overcurrent_override;
  logic       pwm_cutoff;
  logic       fault_req = 1'b0;
  logic       slow = 1'b0;
  logic       shoot;
  int         err_total = 0;
  int         total_checks = 0;
  // ----------------------------------------
  // clock, block and bridge
  // ----------------------------------------
  always #12.5 clk = ~clk;
  motor_drive_protection i_motor_drive_protection (.clk, .nrst, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .drive_in, .comparator_zero_out, .comparator_one_out,
    .current_limit_event, .adc_opa_selected, .capture_compare_stall_event(stall_ev[0]),
    .capture_overflow_stall_event(stall_ev[1]), .pwm_period_start, .gate_out,
    .shutdown_active, .fast_overcurrent_override, .pwm_cutoff);
  gate_bridge_model i_gate_bridge_model (.clk, .gate_out, .fault_req, .slow,
    .sense_oc(comparator_zero_out), .shoot_through(shoot));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // waits land 1 ns past the edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // each bus task waits an edge first, so strobes never double up
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk8(rdata, e);
  endtask
  task automatic gate_is(input logic [3:0] e);
    chk8({4'h0, gate_out}, {4'h0, e});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 5; i++) rd(i[2:0], 8'h00);
    wr(`OFS_OVERRIDE_LEVEL, 8'hF9);
    rd(`OFS_OVERRIDE_LEVEL, 8'h09);
    wr(`OFS_MODE_CONTROL, 8'hFF);
    rd(`OFS_MODE_CONTROL, 8'h7F);
    wr(`OFS_MODE_CONTROL, 8'h00);
    wr(`OFS_STATUS, 8'hFF);
    rd(`OFS_STATUS, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    gate_is(4'h6);
  endtask
  task automatic t_sw_override;
    wr(`OFS_TRIGGER_CONTROL, 8'h02);
    wt(3);
    chk1(fast_overcurrent_override, 1'b1);
    @(posedge clk) drive_in <= 4'h5;
    wt(3);
    gate_is(4'h9);
    chk1(shoot, 1'b0);
    wr(`OFS_TRIGGER_CONTROL, 8'h00);
    wt(3);
    gate_is(4'h5);
  endtask
  task automatic t_sw_pause;
    wr(`OFS_TRIGGER_CONTROL, 8'hC0);
    wt(3);
    chk1(shutdown_active, 1'b0);
    wr(`OFS_MODE_CONTROL, 8'h10);
    wt(3);
    gate_is(`BRAKE_PATTERN);
    rd(`OFS_STATUS, 8'h01);
    wr(`OFS_MOTOR_CONFIG, 8'h01);
    wt(3);
    gate_is(`FREE_RUN_PATTERN);
    wr(`OFS_TRIGGER_CONTROL, 8'h40);
    wt(3);
    chk1(shutdown_active, 1'b0);
    wr(`OFS_MOTOR_CONFIG, 8'h00);
  endtask
  task automatic t_stall(input logic ovf);
    wr(`OFS_MODE_CONTROL, 8'h03);
    for (int en = 0; en < 2; en++) begin
      wr(`OFS_TRIGGER_CONTROL, {1'b0, 1'b1, ovf & en[0], !ovf & en[0], 4'h0});
      @(posedge clk) stall_ev <= {ovf, !ovf};
      @(posedge clk) stall_ev <= 2'b00;
      wt(3);
      chk1(shutdown_active, en[0]);
    end
    rd(`OFS_STATUS, {4'h0, ovf, !ovf, 2'b01});
    wr(`OFS_TRIGGER_CONTROL, {2'b00, ovf, !ovf, 4'h0});
    wr(`OFS_TRIGGER_CONTROL, {2'b01, ovf, !ovf, 4'h0});
    wt(3);
    chk1(shutdown_active, 1'b0);
    wr(`OFS_TRIGGER_CONTROL, 8'h00);
  endtask
  task automatic t_oc;
    wr(`OFS_MODE_CONTROL, 8'h20);
    @(posedge clk) fault_req <= 1'b1;
    wt(12);
    chk1(shutdown_active, 1'b0);
    chk1(pwm_cutoff, 1'b1);
    wr(`OFS_TRIGGER_CONTROL, 8'h08);
    wt(10);
    chk1(shutdown_active, 1'b1);
    @(posedge clk) fault_req <= 1'b0;
    wt(10);
    chk1(shutdown_active, 1'b0);
    chk1(pwm_cutoff, 1'b1);
    @(posedge clk) pwm_period_start <= 1'b1;
    @(posedge clk) pwm_period_start <= 1'b0;
    wt(3);
    chk1(pwm_cutoff, 1'b0);
    wr(`OFS_MODE_CONTROL, 8'h00);
  endtask
  task automatic t_oc_override;
    wr(`OFS_OVERRIDE_LEVEL, 8'h06);
    wr(`OFS_TRIGGER_CONTROL, 8'h09);
    @(posedge clk) fault_req <= 1'b1;
    slow <= 1'b1;
    wt(10);
    @(posedge clk) fault_req <= 1'b0;
    wt(12);
    chk1(fast_overcurrent_override, 1'b1);
    gate_is(4'h6);
    wr(`OFS_TRIGGER_CONTROL, 8'h08);
    wr(`OFS_TRIGGER_CONTROL, 8'h09);
    wt(3);
    chk1(fast_overcurrent_override, 1'b0);
    wr(`OFS_MODE_CONTROL, 8'h40);
    wr(`OFS_TRIGGER_CONTROL, 8'h01);
    @(posedge clk) comparator_one_out <= 1'b1;
    wt(8);
    chk1(fast_overcurrent_override, 1'b1);
    @(posedge clk) comparator_one_out <= 1'b0;
    wr(`OFS_TRIGGER_CONTROL, 8'h00);
    wr(`OFS_TRIGGER_CONTROL, 8'h01);
    wt(3);
    chk1(fast_overcurrent_override, 1'b0);
    wr(`OFS_TRIGGER_CONTROL, 8'h00);
    wr(`OFS_MODE_CONTROL, 8'h00);
  endtask
  task automatic t_climit;
    wr(`OFS_TRIGGER_CONTROL, 8'h04);
    @(posedge clk) current_limit_event <= 1'b1;
    wt(3);
    gate_is(4'h5);
    for (int sel = 0; sel < 2; sel++) begin
      wr(`OFS_MODE_CONTROL, {4'h0, sel[0], 3'h0});
      @(posedge clk) current_limit_event <= 1'b1;
      adc_opa_selected <= 1'b1;
      wt(3);
      gate_is(`BRAKE_PATTERN);
      @(posedge clk) current_limit_event <= 1'b0;
      wt(4);
      gate_is(sel[0] ? `BRAKE_PATTERN : 4'h5);
      @(posedge clk) pwm_period_start <= 1'b1;
      @(posedge clk) pwm_period_start <= 1'b0;
      wt(3);
      gate_is(4'h5);
    end
    wr(`OFS_TRIGGER_CONTROL, 8'h00);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    wt(2);
    @(posedge clk) nrst <= 1'b1;
    wt(2);
    t_regs;
    t_sw_override;
    t_sw_pause;
    t_stall(1'b0);
    t_stall(1'b1);
    t_oc;
    t_oc_override;
    t_climit;
    tally_and_finish;
  end
  // watchdog well past the roughly 270 cycles the scenarios need
  initial begin
    #(25 * 5000);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish;
  end
endmodule
